/* rtl/rpr_bank.sv */
// Reference rank registers for inputs one to four, main and auxiliary banks
`timescale 1ns/100ps
module rpr_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Microprocessor port
   input wire logic [rpr_pkg::ADDR_W-1:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [rpr_pkg::DATA_W-1:0] host_wdata,
   output logic [rpr_pkg::DATA_W-1:0] host_rdata,
   output logic host_rd_valid,
   // Bank select bit from the source select register
   input wire logic path_bank_choice,
   // Main timing path ranks
   output logic [rpr_pkg::DATA_W-1:0] main_pair_one_two,
   output logic [rpr_pkg::DATA_W-1:0] main_pair_three_four,
   output logic [rpr_pkg::IDX_W-1:0] main_best_index,
   output logic main_best_valid,
   // Auxiliary timing path ranks
   output logic [rpr_pkg::DATA_W-1:0] aux_pair_one_two,
   output logic [rpr_pkg::DATA_W-1:0] aux_pair_three_four,
   output logic [rpr_pkg::IDX_W-1:0] aux_best_index,
   output logic aux_best_valid
);

   // ************************************************************
   // Address decode
   // ************************************************************
   wire hit_one_two;     // Access to the pair one and two register
   wire hit_three_four;  // Access to the pair three and four register
   wire pick_main;       // Access steered to the main bank
   wire pick_aux;        // Access steered to the auxiliary bank

   assign hit_one_two = (host_addr == rpr_pkg::OFS_PAIR_ONE_TWO);
   assign hit_three_four = (host_addr == rpr_pkg::OFS_PAIR_THREE_FOUR);
   assign pick_main = (path_bank_choice == rpr_pkg::BANK_MAIN);
   assign pick_aux = (path_bank_choice == rpr_pkg::BANK_AUX);

   // ************************************************************
   // Write strobes
   // ************************************************************
   wire we_main_one_two;     // Store into main pair one and two
   wire we_main_three_four;  // Store into main pair three and four
   wire we_aux_one_two;      // Store into auxiliary pair one and two
   wire we_aux_three_four;   // Store into auxiliary pair three and four

   assign we_main_one_two = host_wr & hit_one_two & pick_main;
   assign we_main_three_four = host_wr & hit_three_four & pick_main;
   assign we_aux_one_two = host_wr & hit_one_two & pick_aux;
   assign we_aux_three_four = host_wr & hit_three_four & pick_aux;

   // ************************************************************
   // Read select
   // ************************************************************
   wire [rpr_pkg::DATA_W-1:0] rd_one_two;     // Pair one and two of chosen bank
   wire [rpr_pkg::DATA_W-1:0] rd_three_four;  // Pair three and four of chosen bank
   wire [rpr_pkg::DATA_W-1:0] next_host_rdata;

   // The bank bit is looked at in the cycle of the read itself
   assign rd_one_two = pick_main ? main_pair_one_two : aux_pair_one_two;
   assign rd_three_four = pick_main ? main_pair_three_four : aux_pair_three_four;
   assign next_host_rdata = hit_one_two ? rd_one_two :
                            hit_three_four ? rd_three_four :
                            rpr_pkg::READ_UNMAPPED;

   // ************************************************************
   // Rank storage
   // ************************************************************
   // Main bank, both nibbles stored as one byte in the printed layout
   always_ff @(posedge clk) begin
      if (reset) begin
         main_pair_one_two <= rpr_pkg::RST_MAIN_ONE_TWO;
         main_pair_three_four <= rpr_pkg::RST_MAIN_THREE_FOUR;
      end else begin
         if (we_main_one_two) begin
            main_pair_one_two <= host_wdata;
         end
         if (we_main_three_four) begin
            main_pair_three_four <= host_wdata;
         end
      end
   end

   // Auxiliary bank, cleared at reset so no input is chosen until software ranks them
   always_ff @(posedge clk) begin
      if (reset) begin
         aux_pair_one_two <= rpr_pkg::RST_AUX_ONE_TWO;
         aux_pair_three_four <= rpr_pkg::RST_AUX_THREE_FOUR;
      end else begin
         if (we_aux_one_two) begin
            aux_pair_one_two <= host_wdata;
         end
         if (we_aux_three_four) begin
            aux_pair_three_four <= host_wdata;
         end
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   // Data held between reads; a read in the cycle of a write sees the old value
   always_ff @(posedge clk) begin
      if (reset) begin
         host_rdata <= rpr_pkg::READ_UNMAPPED;
         host_rd_valid <= 1'b0;
      end else begin
         host_rd_valid <= host_rd;
         if (host_rd) begin
            host_rdata <= next_host_rdata;
         end
      end
   end

   // ************************************************************
   // Automatic choice per path
   // ************************************************************
   // Ranks handed over with input one in the lowest nibble
   wire [rpr_pkg::NUM_IN*rpr_pkg::RANK_W-1:0] main_ranks;
   wire [rpr_pkg::NUM_IN*rpr_pkg::RANK_W-1:0] aux_ranks;
   assign main_ranks = {main_pair_three_four, main_pair_one_two};
   assign aux_ranks = {aux_pair_three_four, aux_pair_one_two};

   // Main timing path
   rpr_rank_pick u_main_pick (
      .clk(clk),
      .reset(reset),
      .ranks(main_ranks),
      .best_index(main_best_index),
      .best_valid(main_best_valid)
   );

   // Auxiliary timing path
   rpr_rank_pick u_aux_pick (
      .clk(clk),
      .reset(reset),
      .ranks(aux_ranks),
      .best_index(aux_best_index),
      .best_valid(aux_best_valid)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   property p_rst_one_two;
      @(posedge clk)
      $past(reset) |-> (main_pair_one_two == rpr_pkg::RST_MAIN_ONE_TWO)
         && (aux_pair_one_two == rpr_pkg::RST_AUX_ONE_TWO);
   endproperty
   a_rst_one_two: assert property (p_rst_one_two)
      else $error("Pair one two reset value wrong");

   property p_rst_three_four;
      @(posedge clk)
      $past(reset) |-> (main_pair_three_four == rpr_pkg::RST_MAIN_THREE_FOUR)
         && (aux_pair_three_four == rpr_pkg::RST_AUX_THREE_FOUR);
   endproperty
   a_rst_three_four: assert property (p_rst_three_four)
      else $error("Pair three four reset value wrong");

   property p_wr_one_two;
      @(posedge clk) disable iff (reset)
      (host_wr && (host_addr == rpr_pkg::OFS_PAIR_ONE_TWO) && !path_bank_choice)
         |=> (main_pair_one_two == $past(host_wdata))
            && $stable(aux_pair_one_two);
   endproperty
   a_wr_one_two: assert property (p_wr_one_two)
      else $error("Main pair one two write not stored");

   property p_wr_three_four;
      @(posedge clk) disable iff (reset)
      (host_wr && (host_addr == rpr_pkg::OFS_PAIR_THREE_FOUR) && path_bank_choice)
         |=> (aux_pair_three_four == $past(host_wdata))
            && $stable(main_pair_three_four);
   endproperty
   a_wr_three_four: assert property (p_wr_three_four)
      else $error("Auxiliary pair three four write not stored");

   property p_bank_keep;
      @(posedge clk) disable iff (reset)
      (!host_wr || !path_bank_choice) |=> $stable(aux_pair_one_two)
         && $stable(aux_pair_three_four);
   endproperty
   a_bank_keep: assert property (p_bank_keep)
      else $error("Auxiliary bank changed without an auxiliary write");

   property p_rd_bank;
      @(posedge clk) disable iff (reset)
      (host_rd && (host_addr == rpr_pkg::OFS_PAIR_THREE_FOUR)) |=>
         host_rd_valid && (host_rdata == ($past(path_bank_choice) ?
            $past(aux_pair_three_four) : $past(main_pair_three_four)));
   endproperty
   a_rd_bank: assert property (p_rd_bank)
      else $error("Read returned data of the wrong bank");

   property p_rd_unmapped;
      @(posedge clk) disable iff (reset)
      (host_rd && (host_addr != rpr_pkg::OFS_PAIR_ONE_TWO)
         && (host_addr != rpr_pkg::OFS_PAIR_THREE_FOUR))
         |=> host_rd_valid && (host_rdata == rpr_pkg::READ_UNMAPPED);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("Unmapped read returned non-zero data");

   // Reads of the lower pair follow the bank bit of the access cycle
   property p_rd_one_two;
      @(posedge clk) disable iff (reset)
      (host_rd && (host_addr == rpr_pkg::OFS_PAIR_ONE_TWO)) |=>
         host_rd_valid && (host_rdata == ($past(path_bank_choice) ?
            $past(aux_pair_one_two) : $past(main_pair_one_two)));
   endproperty
   a_rd_one_two: assert property (p_rd_one_two)
      else $error("Read of pair one two returned data of the wrong bank");

   // A quiet port neither pulses valid nor disturbs the held read data
   property p_rd_quiet;
      @(posedge clk) disable iff (reset)
      !host_rd |=> !host_rd_valid && $stable(host_rdata);
   endproperty
   a_rd_quiet: assert property (p_rd_quiet)
      else $error("Read data moved without a read");

   // Auxiliary traffic must never leak into the main bank
   property p_main_keep;
      @(posedge clk) disable iff (reset)
      (!host_wr || path_bank_choice) |=> $stable(main_pair_one_two)
         && $stable(main_pair_three_four);
   endproperty
   a_main_keep: assert property (p_main_keep)
      else $error("Main bank changed without a main write");

endmodule : rpr_bank

/* rtl/rpr_pkg.sv */
// Constants shared by the reference rank register bank and its rank picker
package rpr_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W = 8;    // Microprocessor port address width
   localparam int DATA_W = 8;    // Register data width
   localparam int RANK_W = 4;    // One rank field
   localparam int NUM_IN = 4;    // Inputs one to four
   localparam int IDX_W = 2;     // Index of an input

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_PAIR_ONE_TWO = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PAIR_THREE_FOUR = 8'h19;

   // ************************************************************
   // Field layout: lower input in low nibble
   // ************************************************************
   localparam int LO_LSB = 0;    // Odd-numbered input of the pair
   localparam int HI_LSB = 4;    // Even-numbered input of the pair

   // ************************************************************
   // Reset values per bank
   // ************************************************************
   localparam logic [DATA_W-1:0] RST_MAIN_ONE_TWO = 8'h32;
   localparam logic [DATA_W-1:0] RST_MAIN_THREE_FOUR = 8'h54;
   localparam logic [DATA_W-1:0] RST_AUX_ONE_TWO = 8'h00;
   localparam logic [DATA_W-1:0] RST_AUX_THREE_FOUR = 8'h00;

   // ************************************************************
   // Codes
   // ************************************************************
   localparam logic [RANK_W-1:0] RANK_OFF = 4'h0;       // Excluded input
   localparam logic BANK_MAIN = 1'b0;                   // Main timing path
   localparam logic BANK_AUX = 1'b1;                    // Auxiliary timing path
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00; // Unmapped read data

endpackage : rpr_pkg

/* rtl/rpr_rank_pick.sv */
// Picks the highest priority candidate among four reference input ranks
`timescale 1ns/100ps
module rpr_rank_pick (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Four packed ranks, input one in the lowest nibble
   input wire logic [rpr_pkg::NUM_IN*rpr_pkg::RANK_W-1:0] ranks,
   // Registered choice
   output logic [rpr_pkg::IDX_W-1:0] best_index,
   output logic best_valid
);

   // ************************************************************
   // Search
   // ************************************************************
   logic [rpr_pkg::IDX_W-1:0] next_best_index; // Winner this cycle
   logic next_best_valid;                      // Any candidate found
   logic [rpr_pkg::RANK_W-1:0] best_rank;      // Rank of the winner so far
   logic [rpr_pkg::RANK_W-1:0] cur_rank;       // Rank under test

   // Ties go to the lower-numbered input, so the scan only replaces on strictly less
   always_comb begin
      next_best_index = '0;
      next_best_valid = 1'b0;
      best_rank = rpr_pkg::RANK_OFF;
      cur_rank = rpr_pkg::RANK_OFF;
      for (int i = 0; i < rpr_pkg::NUM_IN; i++) begin
         cur_rank = ranks[i*rpr_pkg::RANK_W +: rpr_pkg::RANK_W];
         // Zero never qualifies
         if (cur_rank != rpr_pkg::RANK_OFF) begin
            // Any of one to fifteen is a candidate, smaller wins
            if (!next_best_valid || (cur_rank < best_rank)) begin
               next_best_valid = 1'b1;
               next_best_index = rpr_pkg::IDX_W'(i);
               best_rank = cur_rank;
            end
         end
      end
   end

   // Registered so the choice leaves the block from a flip-flop
   always_ff @(posedge clk) begin
      if (reset) begin
         best_index <= '0;
         best_valid <= 1'b0;
      end else begin
         best_index <= next_best_index;
         best_valid <= next_best_valid;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   logic [rpr_pkg::NUM_IN*rpr_pkg::RANK_W-1:0] ranks_q; // Ranks seen by the choice
   always_ff @(posedge clk) begin
      ranks_q <= ranks;
   end

   property p_pick_off;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && best_valid) |->
         (ranks_q[best_index*rpr_pkg::RANK_W +: rpr_pkg::RANK_W] != rpr_pkg::RANK_OFF);
   endproperty
   a_pick_off: assert property (p_pick_off)
      else $error("Chosen input has a zero rank");

   property p_pick_cand;
      @(posedge clk) disable iff (reset)
      !$past(reset) |-> (best_valid == ($past(ranks) != '0));
   endproperty
   a_pick_cand: assert property (p_pick_cand)
      else $error("Candidate present but no input chosen, or the reverse");

   property p_pick_low;
      @(posedge clk) disable iff (reset)
      (!$past(reset) && (ranks_q[rpr_pkg::RANK_W-1:0] != rpr_pkg::RANK_OFF)) |->
         (ranks_q[best_index*rpr_pkg::RANK_W +: rpr_pkg::RANK_W]
            <= ranks_q[rpr_pkg::RANK_W-1:0]);
   endproperty
   a_pick_low: assert property (p_pick_low)
      else $error("Input one has a better rank than the chosen input");

   property p_pick_top;
      @(posedge clk) disable iff (reset)
      (!$past(reset)
         && (ranks_q[rpr_pkg::NUM_IN*rpr_pkg::RANK_W-1 -: rpr_pkg::RANK_W] != rpr_pkg::RANK_OFF))
         |-> (ranks_q[best_index*rpr_pkg::RANK_W +: rpr_pkg::RANK_W]
            <= ranks_q[rpr_pkg::NUM_IN*rpr_pkg::RANK_W-1 -: rpr_pkg::RANK_W]);
   endproperty
   a_pick_top: assert property (p_pick_top)
      else $error("Input four has a better rank than the chosen input");

endmodule : rpr_rank_pick

/* tb/rpr_bank_test.sv */
// Self-checking bench for the reference rank register bank against a behavioural model
`timescale 1ns/100ps
module rpr_bank_test;
   // ************************************************************
   // Signals
   // ************************************************************
   logic clk;                       // 50 MHz clock
   logic reset;                     // Synchronous, active high
   logic [7:0] host_addr;           // Register address
   logic host_wr;                   // Write strobe
   logic host_rd;                   // Read strobe
   logic [7:0] host_wdata;          // Write data
   logic [7:0] host_rdata;          // Read data from the bank
   logic host_rd_valid;             // Read answer pulse
   logic path_bank_choice;          // 0 main bank, 1 auxiliary bank
   logic [7:0] main_pair_one_two, main_pair_three_four;
   logic [7:0] aux_pair_one_two, aux_pair_three_four;
   logic [1:0] main_best_index, aux_best_index;
   logic main_best_valid, aux_best_valid;
   int mismatches;                  // Failed comparisons
   int checked;                     // All comparisons
   int cycles;                      // Timeout counter
   logic [7:0] model [2][2];        // Model registers: bank, pair
   logic [7:0] last_rd;             // Read data that must stand
   logic [31:0] seed;               // Random state

   // ************************************************************
   // Design under test
   // ************************************************************
   rpr_bank uut (.clk(clk), .reset(reset), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_rd_valid(host_rd_valid), .path_bank_choice(path_bank_choice),
      .main_pair_one_two(main_pair_one_two), .main_pair_three_four(main_pair_three_four),
      .main_best_index(main_best_index), .main_best_valid(main_best_valid),
      .aux_pair_one_two(aux_pair_one_two), .aux_pair_three_four(aux_pair_three_four),
      .aux_best_index(aux_best_index), .aux_best_valid(aux_best_valid));

   // Clock generator
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Cut a hang short; the ceiling is well above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_sim();
      end
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   // Xorshift generator so runs repeat exactly
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   // Model pick: smallest non-zero rank, ties to the lower input
   function automatic logic [2:0] best(input logic b);
      logic [3:0] r;
      logic [2:0] res;
      int br;
      res = 3'h0;
      br = 16;
      for (int i = 0; i < 4; i++) begin
         r = 4'(model[b][i/2] >> (4 * (i % 2)));
         if (r != 4'h0 && int'(r) < br) begin
            br = int'(r);
            res = {1'b1, 2'(i)};
         end
      end
      return res;
   endfunction : best

   // Single comparison point
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One port cycle, entered at a falling edge; strobes stay up for back-to-back use
   task automatic op(input logic w, input logic r, input logic b, input logic [7:0] a,
                     input logic [7:0] d);
      logic [7:0] exp_rd;
      logic [2:0] bm, ba;
      exp_rd = (a == 8'h18) ? model[b][0] : (a == 8'h19) ? model[b][1] : 8'h00;
      bm = best(1'b0);
      ba = best(1'b1);
      host_wr = w;
      host_rd = r;
      path_bank_choice = b;
      host_addr = a;
      host_wdata = d;
      @(posedge clk);
      @(negedge clk);
      if (r) last_rd = exp_rd;
      check("rd_valid", {7'h0, host_rd_valid}, {7'h0, r});
      check("rdata", host_rdata, last_rd);
      // Writes to other addresses change nothing
      if (w && a == 8'h18) model[b][0] = d;
      else if (w && a == 8'h19) model[b][1] = d;
      check("main_12", main_pair_one_two, model[0][0]);
      check("main_34", main_pair_three_four, model[0][1]);
      check("aux_12", aux_pair_one_two, model[1][0]);
      check("aux_34", aux_pair_three_four, model[1][1]);
      // Pick lags the registers by one edge, so it matches the pre-write model
      check("main_best", {5'h0, main_best_valid, main_best_index}, {5'h0, bm});
      check("aux_best", {5'h0, aux_best_valid, aux_best_index}, {5'h0, ba});
   endtask : op

   // Verdict
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim

   // Holds reset for n edges, then checks defaults directly and through reads of both banks
   task automatic do_reset(input int n);
      reset = 1'b1;
      host_wr = 1'b0;
      host_rd = 1'b0;
      repeat (n) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      model[0][0] = 8'h32;
      model[0][1] = 8'h54;
      model[1][0] = 8'h00;
      model[1][1] = 8'h00;
      last_rd = 8'h00;
      check("rst_main_12", main_pair_one_two, 8'h32);
      check("rst_aux_12", aux_pair_one_two, 8'h00);
      check("rst_main_34", main_pair_three_four, 8'h54);
      check("rst_aux_34", aux_pair_three_four, 8'h00);
      for (int i = 0; i < 4; i++) op(1'b0, 1'b1, i[1], 8'h18 + 8'(i[0]), 8'h00);
   endtask : do_reset

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      logic [7:0] a, d;
      mismatches = 0;
      checked = 0;
      cycles = 0;
      seed = 32'hde6f0f1e;
      {path_bank_choice, host_addr, host_wdata} = '0;
      // Reset contents straight from the outputs, then read through both banks
      do_reset(16);
      $display("Test reset done");
      // Bank steering, same-cycle read and write, unmapped places
      op(1'b1, 1'b0, 1'b0, 8'h18, 8'h21);
      op(1'b1, 1'b1, 1'b1, 8'h18, 8'h9a);
      op(1'b0, 1'b1, 1'b0, 8'h18, 8'h00);
      op(1'b0, 1'b1, 1'b1, 8'h18, 8'h00);
      op(1'b1, 1'b0, 1'b1, 8'h19, 8'hf0);
      op(1'b0, 1'b1, 1'b1, 8'h19, 8'h00);
      op(1'b1, 1'b0, 1'b0, 8'h1a, 8'hff);
      op(1'b0, 1'b1, 1'b0, 8'h1a, 8'h00);
      op(1'b0, 1'b1, 1'b1, 8'h17, 8'h00);
      $display("Test banks done");
      // All-zero ranks drop out; rank fifteen alone is still a candidate
      op(1'b1, 1'b0, 1'b1, 8'h18, 8'h00);
      op(1'b1, 1'b0, 1'b1, 8'h19, 8'h00);
      op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      check("aux_off", {7'h0, aux_best_valid}, 8'h00);
      op(1'b1, 1'b0, 1'b1, 8'h19, 8'hf0);
      op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      check("aux_fifteen", {5'h0, aux_best_valid, aux_best_index}, 8'h07);
      $display("Test exclusion done");
      // Random traffic, zero nibbles made common to stress the pick
      repeat (400) begin
         seed = xs(seed);
         a = (seed[4:3] == 2'h3) ? seed[15:8] : (seed[3] ? 8'h19 : 8'h18);
         d = seed[23:16] & {{4{seed[24]}}, {4{seed[25]}}};
         op(seed[0], seed[1], seed[2], a, d);
      end
      op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      $display("Test random done");
      // A second reset after traffic must bring back the defaults in both banks
      do_reset(2);
      $display("Test mid reset done");
      end_sim();
   end
endmodule : rpr_bank_test
